/* File: rtl/pmc_consts.vh */
// Constants of the power mode controller
`ifndef PMC_CONSTS_VH
`define PMC_CONSTS_VH
// Mode codes, as shown in the two-bit mode status field
`define PMC_MODE_SLEEP 2'b00
`define PMC_MODE_LIMP 2'b01
`define PMC_MODE_IDLE 2'b10
`define PMC_MODE_ACTIVE 2'b11
// Core clock in kHz and power-on reset release delay in ns
`define PMC_CLK_KHZ 40000
`define PMC_SLEEP2IDLE_NS 10000
// Cycles of the release delay, rounded up
`define PMC_SLEEP2IDLE_CYC ((`PMC_SLEEP2IDLE_NS * `PMC_CLK_KHZ + 999999) / 1000000)
// Channel count and default limp-home channels
`define PMC_NCH 8
`define PMC_LIMP_CH_A 2
`define PMC_LIMP_CH_B 3
`endif

/* File: rtl/pmc_mode_ctrl.v */
// Operating-mode controller of an eight-channel low-side driver
`timescale 1ns/1ps
`default_nettype none
`include "pmc_consts.vh"
module pmc_mode_ctrl #(
   parameter NCH = `PMC_NCH,
   parameter POR_CYCLES = `PMC_SLEEP2IDLE_CYC
) (
   input wire CLK, // Core clock, 40 MHz
   input wire SRST, // Synchronous reset, active high
   input wire STANDBY_PIN, // Standby pin level (async)
   input wire [1:0] DIRECT_INPUT_PIN, // Direct input pins (async)
   input wire BATT_PRESENT, // Battery supply above power-up level
   input wire LOGIC_PRESENT, // Logic supply above power-up level
   input wire BATT_UV, // Battery undervoltage detector
   input wire LOGIC_UV, // Logic-supply undervoltage detector
   input wire INT_SUPPLY_FAIL, // Internal supply or reference failure
   input wire [NCH-1:0] SPI_OUTPUT_DRIVE_BITS, // SPI channel on bits
   input wire [NCH-1:0] PWM_OUTPUT_MAPPING_BITS, // PWM mapping bits
   input wire [NCH-1:0] PWM_GENERATOR_SELECT_BITS, // PWM gen select
   input wire [1:0] PWM_GEN_OUT, // Current PWM generator outputs
   input wire [NCH-1:0] INPUT_MAP_0, // Channels driven by input 0
   input wire [NCH-1:0] INPUT_MAP_1, // Channels driven by input 1
   input wire FORCE_ACTIVE_BIT, // Force active configuration
   input wire SLEEP_SWITCH_OFF_BIT, // Allow switch-off into sleep
   input wire UNDERVOLTAGE_MASK_BIT, // Channels kept under battery UV
   input wire STATUS_READ, // Pulse: second status register read
   input wire SPI_WRITE_REQ, // Pulse: SPI register write request
   output reg [1:0] MODE, // Two-bit mode status field
   output reg [NCH-1:0] CHANNEL_EN, // Channel actuation
   output reg SPI_ENABLE, // SPI communication allowed
   output reg SPI_WRITE_EN, // SPI register writes accepted
   output reg REG_RESET, // Hold read/write registers at default
   output reg POR_ACTIVE, // Internal power-on reset asserted
   output reg POWER_ON_RESET_FLAG // Sticky POR flag
);
   // ==========================================================
   // Pin synchronisation
   wire stby_s;
   wire [1:0] din_s;
   wire [2:0] pins_s;
   pmc_sync #(
      .W(3)
   ) u_sync (
      .CLK(CLK),
      .SRST(SRST),
      .ASYNC_IN({STANDBY_PIN, DIRECT_INPUT_PIN}),
      .SYNC_OUT(pins_s)
   );
   assign stby_s = pins_s[2];
   assign din_s = pins_s[1:0];

   // ==========================================================
   // Power-on reset
   wire any_pin = stby_s | din_s[0] | din_s[1];
   wire supply_ok = BATT_PRESENT | LOGIC_PRESENT;
   // Logic UV with both inputs low is a full logic reset too
   wire por_cond;
   wire por_released;
   pmc_por_timer #(
      .CYCLES(POR_CYCLES)
   ) u_por (
      .CLK(CLK),
      .SRST(SRST),
      .HOLD(por_cond),
      .RELEASED(por_released)
   );
   wire por_n = por_released;
   reg por_n_q;
   always @(posedge CLK)
   begin
      if (SRST)
         por_n_q <= 1'b0;
      else
         por_n_q <= por_n;
   end

   // ==========================================================
   // Channel requests
   wire [NCH-1:0] pwm_req;
   genvar g;
   generate
      for (g = 0; g < NCH; g = g + 1)
      begin : g_pwm
         assign pwm_req[g] = PWM_OUTPUT_MAPPING_BITS[g] &
                             PWM_GEN_OUT[PWM_GENERATOR_SELECT_BITS[g]];
      end
   endgenerate
   // Registers are at default while the logic supply is low
   wire regs_valid = !LOGIC_UV && LOGIC_PRESENT;
   wire [NCH-1:0] spi_req = regs_valid ?
                            (SPI_OUTPUT_DRIVE_BITS | pwm_req) :
                            {NCH{1'b0}};
   wire [NCH-1:0] pin_req = ({NCH{din_s[0]}} & INPUT_MAP_0) |
                            ({NCH{din_s[1]}} & INPUT_MAP_1);
   wire any_soft = |spi_req;
   wire on_req = any_soft || (din_s != 2'b00);

   // ==========================================================
   // Mode state machine
   localparam [1:0] ST_SLEEP = `PMC_MODE_SLEEP;
   localparam [1:0] ST_LIMP = `PMC_MODE_LIMP;
   localparam [1:0] ST_IDLE = `PMC_MODE_IDLE;
   localparam [1:0] ST_ACTIVE = `PMC_MODE_ACTIVE;
   reg [1:0] mode_q;
   reg [1:0] mode_d;
   // Software-driven channels keep the core powered with all pins low,
   // otherwise the power-down reset would bypass the sleep block
   wire hold_awake = (mode_q == ST_ACTIVE) && any_soft &&
                     !SLEEP_SWITCH_OFF_BIT;
   assign por_cond = !supply_ok || INT_SUPPLY_FAIL ||
                     (!any_pin && !hold_awake) ||
                     (LOGIC_UV && din_s == 2'b00);
   always @*
   begin
      mode_d = mode_q;
      case (mode_q)
         ST_SLEEP:
         begin
            if (por_n && stby_s)
               mode_d = on_req ? ST_ACTIVE : ST_IDLE;
            else if (por_n && din_s != 2'b00)
               mode_d = ST_LIMP;
         end
         ST_IDLE:
         begin
            if (!stby_s && din_s == 2'b00)
               mode_d = ST_SLEEP;
            else if (!stby_s)
               mode_d = ST_LIMP;
            else if (FORCE_ACTIVE_BIT || on_req)
               mode_d = ST_ACTIVE;
         end
         ST_ACTIVE:
         begin
            if (!stby_s && din_s == 2'b00)
            begin
               // Software-driven channels block sleep unless allowed
               if (!any_soft || SLEEP_SWITCH_OFF_BIT)
                  mode_d = ST_SLEEP;
            end
            else if (!stby_s)
               mode_d = ST_LIMP;
            else if (!FORCE_ACTIVE_BIT && !on_req)
               mode_d = ST_IDLE;
         end
         ST_LIMP:
         begin
            if (stby_s)
               mode_d = on_req ? ST_ACTIVE : ST_IDLE;
            else if (din_s == 2'b00)
               mode_d = ST_SLEEP;
         end
         default:
            mode_d = ST_SLEEP;
      endcase
   end
   always @(posedge CLK)
   begin
      if (SRST || !por_n)
         mode_q <= ST_SLEEP;
      else
         mode_q <= mode_d;
   end

   // ==========================================================
   // Channel gating
   // Channels follow the registered mode, so a request that forces
   // a mode change waits for that change before turning on.
   reg [NCH-1:0] ch_d;
   reg [NCH-1:0] limp_ch;
   always @*
   begin
      limp_ch = {NCH{1'b0}};
      limp_ch[`PMC_LIMP_CH_A] = 1'b1;
      limp_ch[`PMC_LIMP_CH_B] = 1'b1;
      ch_d = {NCH{1'b0}};
      case (mode_q)
         ST_ACTIVE:
            ch_d = spi_req | pin_req;
         ST_LIMP:
            ch_d = pin_req & limp_ch;
         default:
            ch_d = {NCH{1'b0}};
      endcase
      if (!BATT_PRESENT)
         ch_d = {NCH{1'b0}};
      else if (BATT_UV)
      begin
         if (!UNDERVOLTAGE_MASK_BIT || !regs_valid)
            ch_d = {NCH{1'b0}};
         else if (mode_q == ST_LIMP)
            ch_d = ch_d & limp_ch;
      end
   end
   // Under POR the channels drop with the reset, not a timed ramp
   always @(posedge CLK)
   begin
      if (SRST || !por_n)
         CHANNEL_EN <= {NCH{1'b0}};
      else
         CHANNEL_EN <= ch_d;
   end

   // ==========================================================
   // SPI gating, status field and POR flag
   always @(posedge CLK)
   begin
      if (SRST)
      begin
         MODE <= ST_SLEEP;
         SPI_ENABLE <= 1'b0;
         SPI_WRITE_EN <= 1'b0;
         REG_RESET <= 1'b1;
         POR_ACTIVE <= 1'b1;
         POWER_ON_RESET_FLAG <= 1'b0;
      end
      else
      begin
         MODE <= mode_q;
         POR_ACTIVE <= !por_n;
         SPI_ENABLE <= regs_valid && mode_q != ST_SLEEP && por_n;
         SPI_WRITE_EN <= regs_valid && por_n &&
                         (mode_q == ST_IDLE || mode_q == ST_ACTIVE) &&
                         !SPI_WRITE_REQ_blocked(mode_q);
         REG_RESET <= !regs_valid || !por_n || mode_q == ST_SLEEP;
         // A new POR event beats a read in the same cycle
         if (por_n_q && !por_n)
            POWER_ON_RESET_FLAG <= 1'b1;
         else if (!por_n_q && por_n)
            POWER_ON_RESET_FLAG <= 1'b1;
         else if (STATUS_READ)
            POWER_ON_RESET_FLAG <= 1'b0;
      end
   end

   // Writes are refused in limp-home even while a request is pending
   function SPI_WRITE_REQ_blocked;
      input [1:0] m;
      begin
         SPI_WRITE_REQ_blocked = (m == ST_LIMP) & SPI_WRITE_REQ;
      end
   endfunction
endmodule // pmc_mode_ctrl
`default_nettype wire

/* File: rtl/pmc_por_timer.v */
// Power-on reset release timer
`timescale 1ns/1ps
`default_nettype none
`include "pmc_consts.vh"
module pmc_por_timer #(
   parameter CYCLES = `PMC_SLEEP2IDLE_CYC
) (
   input wire CLK, // Core clock
   input wire SRST, // Synchronous reset
   input wire HOLD, // High keeps reset asserted and count cleared
   output wire RELEASED // High once the delay has elapsed
);
   reg [15:0] cnt_q;
   reg done_q;
   always @(posedge CLK)
   begin
      if (SRST || HOLD)
      begin
         cnt_q <= 16'h0000;
         done_q <= 1'b0;
      end
      else if (!done_q)
      begin
         if (cnt_q == CYCLES[15:0] - 16'h0001)
            done_q <= 1'b1;
         cnt_q <= cnt_q + 16'h0001;
      end
   end
   assign RELEASED = done_q;
endmodule // pmc_por_timer
`default_nettype wire

/* File: rtl/pmc_sync.v */
// Two flip-flop synchroniser for a bus of pin levels
`timescale 1ns/1ps
`default_nettype none
module pmc_sync #(
   parameter W = 3
) (
   input wire CLK, // Core clock
   input wire SRST, // Synchronous reset
   input wire [W-1:0] ASYNC_IN, // Pin levels
   output wire [W-1:0] SYNC_OUT // Synchronised levels
);
   reg [W-1:0] meta_q;
   reg [W-1:0] sync_q;
   always @(posedge CLK)
   begin
      if (SRST)
      begin
         meta_q <= {W{1'b0}};
         sync_q <= {W{1'b0}};
      end
      else
      begin
         meta_q <= ASYNC_IN;
         sync_q <= meta_q;
      end
   end
   assign SYNC_OUT = sync_q;
endmodule // pmc_sync
`default_nettype wire

/* File: verification/pmc_host_model.sv */
// Host model driving the standby and direct input pins
`timescale 1ns/1ps
`default_nettype none
module pmc_host_model (
   input wire logic CLK, // Core clock
   input wire logic SLOW, // One extra cycle before pins follow
   input wire logic [2:0] REQ, // Wanted standby and input levels
   output logic [2:0] PINS // Standby in bit 2, inputs below
);
   logic [2:0] dly_q = 3'h0;
   initial PINS = 3'h0;
   // =====
   // Pins move just after the edge, as a firmware port write would
   always @(posedge CLK)
   begin
      dly_q <= REQ;
      PINS <= #2 SLOW ? dly_q : REQ;
   end
endmodule // pmc_host_model
`default_nettype wire

/* File: verification/pmc_mode_ctrl_asserts.sv */
// Port assertions of the power mode controller
`timescale 1ns/1ps
`default_nettype none
`include "pmc_consts.vh"
module pmc_mode_ctrl_asserts #(
   parameter NCH = 8,
   parameter POR_CYCLES = 8
) (
   input wire logic CLK, // Core clock
   input wire logic SRST, // Sync reset
   input wire logic STANDBY_PIN, // Standby pin
   input wire logic [1:0] DIRECT_INPUT_PIN, // Input pins
   input wire logic BATT_UV, // Battery UV
   input wire logic LOGIC_UV, // Logic UV
   input wire logic [NCH-1:0] SPI_OUTPUT_DRIVE_BITS, // SPI drive
   input wire logic [NCH-1:0] PWM_OUTPUT_MAPPING_BITS, // PWM map
   input wire logic FORCE_ACTIVE_BIT, // Force active
   input wire logic SLEEP_SWITCH_OFF_BIT, // Sleep switch-off
   input wire logic UNDERVOLTAGE_MASK_BIT, // UV mask
   input wire logic SPI_WRITE_REQ, // Write attempt
   input wire logic [1:0] MODE, // Mode field
   input wire logic [NCH-1:0] CHANNEL_EN, // Channels
   input wire logic SPI_ENABLE, // SPI allowed
   input wire logic SPI_WRITE_EN, // Writes allowed
   input wire logic REG_RESET, // Registers held
   input wire logic POR_ACTIVE, // Internal reset
   input wire logic POWER_ON_RESET_FLAG // Sticky flag
);
   // =====
   // Properties
   default clocking @(posedge CLK); endclocking
   default disable iff (SRST);
   // Held conditions allow for pin sync and output register latency
   sequence uv_held;
      (BATT_UV && !UNDERVOLTAGE_MASK_BIT) [*3];
   endsequence
   sequence all_quiet;
      (!STANDBY_PIN && DIRECT_INPUT_PIN == 2'b00 && !FORCE_ACTIVE_BIT
       && SPI_OUTPUT_DRIVE_BITS == 0 && PWM_OUTPUT_MAPPING_BITS == 0) [*8];
   endsequence
   batt_uv_off_a:
      assert property (uv_held |-> CHANNEL_EN == 0)
      else $error("channels on under battery undervoltage");
   logic_uv_spi_a:
      assert property (LOGIC_UV [*3] |-> !SPI_ENABLE && !SPI_WRITE_EN
         && REG_RESET) else $error("SPI open under logic undervoltage");
   limp_no_write_a:
      assert property (MODE == `PMC_MODE_LIMP && SPI_WRITE_REQ
         |=> !SPI_WRITE_EN) else $error("write accepted in limp mode");
   limp_chans_a:
      assert property (MODE == `PMC_MODE_LIMP [*2]
         |-> (CHANNEL_EN & 8'hf3) == 8'h00)
      else $error("non-default channel on in limp mode");
   quiet_sleep_a:
      assert property (all_quiet |-> MODE == `PMC_MODE_SLEEP)
      else $error("no sleep with all pins low");
   sleep_block_a:
      assert property (MODE == `PMC_MODE_ACTIVE && !SLEEP_SWITCH_OFF_BIT
         && SPI_OUTPUT_DRIVE_BITS != 0 |=> MODE != `PMC_MODE_SLEEP)
      else $error("sleep entered with a channel driven");
   por_flag_a:
      assert property ($fell(POR_ACTIVE) |-> ##[0:2] POWER_ON_RESET_FLAG)
      else $error("reset flag not set");
   por_delay_a:
      assert property ($fell(POR_ACTIVE) |-> $past(POR_ACTIVE, POR_CYCLES))
      else $error("internal reset released early");
   force_act_a:
      assert property ((FORCE_ACTIVE_BIT && STANDBY_PIN && !POR_ACTIVE
         && !LOGIC_UV) [*5] |-> MODE == `PMC_MODE_ACTIVE)
      else $error("force active not honoured");
endmodule // pmc_mode_ctrl_asserts
bind pmc_mode_ctrl pmc_mode_ctrl_asserts #(.NCH(NCH),
   .POR_CYCLES(POR_CYCLES)) chk (.CLK, .SRST, .STANDBY_PIN,
   .DIRECT_INPUT_PIN, .BATT_UV, .LOGIC_UV, .SPI_OUTPUT_DRIVE_BITS,
   .PWM_OUTPUT_MAPPING_BITS, .FORCE_ACTIVE_BIT, .SLEEP_SWITCH_OFF_BIT,
   .UNDERVOLTAGE_MASK_BIT, .SPI_WRITE_REQ, .MODE, .CHANNEL_EN,
   .SPI_ENABLE, .SPI_WRITE_EN, .REG_RESET, .POR_ACTIVE,
   .POWER_ON_RESET_FLAG);
`default_nettype wire

/* File: verification/pmc_mode_ctrl_bench.sv */
// Self-checking bench of the power mode controller
`timescale 1ns/1ps
`default_nettype none
`include "pmc_consts.vh"
module pmc_mode_ctrl_bench;
   localparam PC = 8;
   logic clk, srst, bp, buv, luv, frc, sso, mask, rd, wr, slow;
   logic [1:0] pg, mode;
   logic [2:0] req, pins;
   logic [7:0] spi, pmap, ch;
   logic spien, wren, regrst, por, flag;
   int num_errors = 0;
   int checks_done = 0;
   pmc_host_model host (.CLK(clk), .SLOW(slow), .REQ(req), .PINS(pins));
   pmc_mode_ctrl #(.POR_CYCLES(PC)) dut (.CLK(clk), .SRST(srst),
      .STANDBY_PIN(pins[2]), .DIRECT_INPUT_PIN(pins[1:0]),
      .BATT_PRESENT(bp), .LOGIC_PRESENT(1'b1), .BATT_UV(buv),
      .LOGIC_UV(luv), .INT_SUPPLY_FAIL(1'b0), .SPI_OUTPUT_DRIVE_BITS(spi),
      .PWM_OUTPUT_MAPPING_BITS(pmap), .PWM_GENERATOR_SELECT_BITS(8'h00),
      .PWM_GEN_OUT(pg), .INPUT_MAP_0(8'h04), .INPUT_MAP_1(8'h08),
      .FORCE_ACTIVE_BIT(frc), .SLEEP_SWITCH_OFF_BIT(sso),
      .UNDERVOLTAGE_MASK_BIT(mask), .STATUS_READ(rd), .SPI_WRITE_REQ(wr),
      .MODE(mode), .CHANNEL_EN(ch), .SPI_ENABLE(spien),
      .SPI_WRITE_EN(wren), .REG_RESET(regrst), .POR_ACTIVE(por),
      .POWER_ON_RESET_FLAG(flag));
   initial
   begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end
   // =====
   // Shared tasks
   task final_report;
      if (num_errors == 0 && checks_done > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask
   task chk(input string nm, input logic [7:0] e, input logic [7:0] g);
      checks_done++;
      if (g !== e)
      begin
         num_errors++;
         $display("[FAIL] %s exp %h got %h", nm, e, g);
      end
   endtask
   // Inputs always change 2 ns after the edge
   task cyc(input int n);
      repeat (n) @(posedge clk);
      #2;
   endtask
   task wmode(input logic [1:0] m);
      int n;
      n = 60;
      while (mode !== m && n > 0)
      begin
         cyc(1);
         n--;
      end
      chk("MODE", {6'h0, m}, {6'h0, mode});
      if (mode !== m)
         final_report;
   endtask
   task wpor;
      int n;
      n = 0;
      while (por !== 1'b0 && n < 40)
      begin
         cyc(1);
         n++;
      end
      chk("POR delay ok", 8'h1, {7'h0, n >= PC && n < 40});
      if (n >= 40)
         final_report;
   endtask
   // =====
   // Scenarios
   task t_wake;
      chk("reset MODE", 8'h0, {6'h0, mode});
      chk("reset REG_RESET", 8'h1, {7'h0, regrst});
      req = 3'b100;
      wpor;
      wmode(`PMC_MODE_IDLE);
      chk("flag set", 8'h1, {7'h0, flag});
      chk("SPI_ENABLE", 8'h1, {7'h0, spien});
      rd = 1'b1;
      cyc(1);
      rd = 1'b0;
      cyc(2);
      chk("flag cleared", 8'h0, {7'h0, flag});
   endtask
   task t_active;
      spi = 8'h81;
      wmode(`PMC_MODE_ACTIVE);
      chk("CHANNEL_EN", 8'h81, ch);
      buv = 1'b1;
      cyc(4);
      chk("CHANNEL_EN uv", 8'h00, ch);
      mask = 1'b1;
      cyc(4);
      chk("CHANNEL_EN masked", 8'h81, ch);
      mask = 1'b0;
      buv = 1'b0;
      cyc(4);
      chk("CHANNEL_EN back", 8'h81, ch);
      spi = 8'h00;
      pmap = 8'h01;
      pg = 2'b01;
      wmode(`PMC_MODE_ACTIVE);
      pmap = 8'h00;
      wmode(`PMC_MODE_IDLE);
      luv = 1'b1;
      cyc(4);
      chk("SPI_ENABLE luv", 8'h0, {7'h0, spien});
      chk("REG_RESET luv", 8'h1, {7'h0, regrst});
      luv = 1'b0;
      frc = 1'b1;
      wmode(`PMC_MODE_ACTIVE);
      frc = 1'b0;
      wmode(`PMC_MODE_IDLE);
   endtask
   task t_sleep;
      spi = 8'h02;
      wmode(`PMC_MODE_ACTIVE);
      req = 3'b000;
      cyc(12);
      chk("MODE held", {6'h0, `PMC_MODE_ACTIVE}, {6'h0, mode});
      sso = 1'b1;
      wmode(`PMC_MODE_SLEEP);
      chk("CHANNEL_EN sleep", 8'h00, ch);
      spi = 8'h00;
      sso = 1'b0;
      cyc(2);
   endtask
   task t_limp;
      slow = 1'b1;
      req = 3'b001;
      wpor;
      wmode(`PMC_MODE_LIMP);
      cyc(2);
      chk("CHANNEL_EN limp", 8'h04, ch);
      wr = 1'b1;
      cyc(1);
      wr = 1'b0;
      cyc(1);
      chk("SPI_WRITE_EN", 8'h0, {7'h0, wren});
      req = 3'b000;
      wmode(`PMC_MODE_SLEEP);
      bp = 1'b0;
      req = 3'b010;
      wpor;
      wmode(`PMC_MODE_LIMP);
      cyc(4);
      chk("CHANNEL_EN no batt", 8'h00, ch);
   endtask
   initial
   begin
      srst = 1'b1;
      {bp, buv, luv, frc, sso, mask, rd, wr, slow} = 9'h100;
      pg = 2'b00;
      req = 3'b000;
      spi = 8'h00;
      pmap = 8'h00;
      cyc(20);
      srst = 1'b0;
      cyc(1);
      t_wake;
      t_active;
      t_sleep;
      t_limp;
      final_report;
   end
endmodule // pmc_mode_ctrl_bench
`default_nettype wire
